// ---- include/ccg_pkg.sv ----
// constants, types and field layout for the processor clock, reset and ready generator
// assumes a single 10 MHz aclk and an AXI4-Lite master for the control registers
//
// Operation
// [RL1] source clock divided by three, output high one source period in three
// [RL2] counter has a clear input that stops counting to align clock phase
// [RL3] clear high holds counters reset; counting resumes once clear goes low
// [RL4] far side synchronises the clear to the external clock with two flip-flops
// [RL5] static strap picks oscillator or external frequency input as counter source
// [RL6] strap high selects external frequency input, low selects the oscillator
// [RL7] buffered oscillator signal always driven on the oscillator output
// [RL8] peripheral clock runs at half the processor clock with 50% duty
// [RL9] reset request passes a flip-flop clocked on the processor clock falling edge
// [RL10] reset request is active low, processor reset output active high
// [RL11] two bus-ready inputs, each recognised only while its own qualifier is asserted
// [RL12] qualifiers are active low: low validates the ready input, high disables it
// [RL13] combined ready is true when any ready input is high with qualifier low
// [RL14] without multiple bus masters the far side ties each qualifier low
// [RL15] two-stage mode: rising ready caught on rising edge, then falling edge sets ready
// [RL16] two-stage mode: falling ready clears the second stage directly on falling edge
// [RL17] sync-mode high bypasses the first stage; second stage samples on falling edge
// [RL18] sync-mode select may change on any bus cycle and takes effect at once
// [RL19] a ready source may skip synchronisation on deassertion if it meets setup by design
package ccg_pkg;

    // register byte offsets
    localparam logic [3:0] CCG_OFS_CTRL = 4'h0;
    localparam logic [3:0] CCG_OFS_STATUS = 4'h4;
    localparam logic [3:0] CCG_OFS_CYCLES = 4'h8;

    // control register fields
    localparam int CCG_CTRL_SOFT_CLEAR = 0;
    localparam int CCG_CTRL_SOFT_RESET = 1;
    localparam logic [1:0] CCG_CTRL_RESET = 2'h0;

    // status register fields
    localparam int CCG_ST_CPU_CLK = 0;
    localparam int CCG_ST_PERIPH_CLK = 1;
    localparam int CCG_ST_CPU_RESET = 2;
    localparam int CCG_ST_READY = 3;
    localparam int CCG_ST_SOURCE_SEL = 4;
    localparam int CCG_ST_SYNC_MODE = 5;
    localparam int CCG_ST_CLEAR = 6;
    localparam int CCG_ST_PHASE_LO = 8;

    // divide-by-three phase counter
    localparam logic [1:0] CCG_PHASE_HIGH = 2'h0;
    localparam logic [1:0] CCG_PHASE_LAST = 2'h2;

    // values after reset
    localparam logic CCG_CPU_RESET_INIT = 1'b1;
    localparam logic [31:0] CCG_CYCLES_INIT = 32'h0000_0000;

    // axi responses
    localparam logic [1:0] CCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCG_RESP_SLVERR = 2'h2;

    // pins that arrive from outside the aclk domain
    typedef struct packed {
        logic oscillator_in;
        logic external_frequency_in;
        logic source_select;
        logic counter_sync_clear;
        logic reset_request_n;
        logic bus_ready_in_1;
        logic bus_ready_in_2;
        logic ready_qualifier_n_1;
        logic ready_qualifier_n_2;
        logic sync_mode_select;
    } ccg_pin_t;

endpackage

// ---- rtl/ccg_clock_gen.sv ----
// processor clock, peripheral clock, reset and ready generator with an AXI4-Lite window
// assumes source clocks at most a quarter of aclk so every edge is seen after synchronising
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module ccg_clock_gen
    import ccg_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // clock sources and strap
    input wire logic oscillator_in,
    input wire logic external_frequency_in,
    input wire logic source_select,
    input wire logic counter_sync_clear,
    // reset request
    input wire logic reset_request_n,
    // bus ready inputs
    input wire logic bus_ready_in_1,
    input wire logic bus_ready_in_2,
    input wire logic ready_qualifier_n_1,
    input wire logic ready_qualifier_n_2,
    input wire logic sync_mode_select,
    // generated outputs
    output logic oscillator_out,
    output logic cpu_clk,
    output logic periph_clk,
    output logic cpu_reset,
    output logic ready,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ccg_pin_t pins_raw;
    ccg_pin_t pins;

    // every pin passes two flops before any logic looks at it
    assign pins_raw = '{
        oscillator_in: oscillator_in,
        external_frequency_in: external_frequency_in,
        source_select: source_select,
        counter_sync_clear: counter_sync_clear,
        reset_request_n: reset_request_n,
        bus_ready_in_1: bus_ready_in_1,
        bus_ready_in_2: bus_ready_in_2,
        ready_qualifier_n_1: ready_qualifier_n_1,
        ready_qualifier_n_2: ready_qualifier_n_2,
        sync_mode_select: sync_mode_select
    };

    ccg_sync #(
        .WIDTH($bits(ccg_pin_t))
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pins_raw),
        .q(pins)
    );

    // control register
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;

    // divider state
    logic src_prev;
    logic [1:0] phase;
    logic [31:0] cycles;
    logic next_src_prev;
    logic [1:0] next_phase;
    logic next_cpu_clk;
    logic next_periph_clk;
    logic [31:0] next_cycles;

    logic src_level;
    logic src_edge;
    logic clear_active;
    logic rise_evt;
    logic fall_evt;

    always_comb begin
        // static strap picks the source feeding the divider
        src_level = pins.source_select ? pins.external_frequency_in
                                       : pins.oscillator_in; // RL5 RL6
        src_edge = src_level & ~src_prev;
        clear_active = pins.counter_sync_clear | ctrl[CCG_CTRL_SOFT_CLEAR]; // RL2
        next_src_prev = src_level;
        next_phase = phase;
        next_cpu_clk = cpu_clk;
        next_periph_clk = periph_clk;
        next_cycles = cycles;
        rise_evt = 1'b0;
        fall_evt = 1'b0;
        if (clear_active) begin
            // parked on the last phase so the first edge after release starts a high phase
            next_phase = CCG_PHASE_LAST; // RL3
            next_cpu_clk = 1'b0; // RL3
            next_periph_clk = 1'b0; // RL3
        end else if (src_edge) begin
            if (phase == CCG_PHASE_LAST) begin
                next_phase = CCG_PHASE_HIGH; // RL1
            end else begin
                next_phase = phase + 2'h1; // RL1
            end
            next_cpu_clk = (next_phase == CCG_PHASE_HIGH); // RL1
            rise_evt = next_cpu_clk & ~cpu_clk;
            fall_evt = cpu_clk & ~next_cpu_clk;
            if (rise_evt) begin
                next_periph_clk = ~periph_clk; // RL8
                next_cycles = cycles + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev <= 1'b0;
            phase <= CCG_PHASE_LAST;
            cpu_clk <= 1'b0;
            periph_clk <= 1'b0;
            cycles <= CCG_CYCLES_INIT;
        end else begin
            src_prev <= next_src_prev;
            phase <= next_phase;
            cpu_clk <= next_cpu_clk;
            periph_clk <= next_periph_clk;
            cycles <= next_cycles;
        end
    end

    // reset and ready stages, stepped by the processor clock events
    logic rdy_stage1;
    logic next_rdy_stage1;
    logic next_ready;
    logic next_cpu_reset;
    logic next_oscillator_out;
    logic ready_qualified;

    always_comb begin
        ready_qualified = (pins.bus_ready_in_1 & ~pins.ready_qualifier_n_1)
                        | (pins.bus_ready_in_2 & ~pins.ready_qualifier_n_2); // RL11 RL12 RL13
        next_oscillator_out = pins.oscillator_in; // RL7
        next_rdy_stage1 = rdy_stage1;
        next_ready = ready;
        next_cpu_reset = cpu_reset;
        if (rise_evt) begin
            next_rdy_stage1 = ready_qualified; // RL15
        end
        if (fall_evt) begin
            next_cpu_reset = ~pins.reset_request_n | ctrl[CCG_CTRL_SOFT_RESET]; // RL9 RL10
            // mode is looked at on every falling edge, so it may change per bus cycle
            if (pins.sync_mode_select) begin
                next_ready = ready_qualified; // RL17 RL18
            end else begin
                // falling ready drops straight through, rising waits for stage one
                next_ready = rdy_stage1 & ready_qualified; // RL15 RL16 RL18
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdy_stage1 <= 1'b0;
            ready <= 1'b0;
            cpu_reset <= CCG_CPU_RESET_INIT;
            oscillator_out <= 1'b0;
        end else begin
            rdy_stage1 <= next_rdy_stage1;
            ready <= next_ready;
            cpu_reset <= next_cpu_reset;
            oscillator_out <= next_oscillator_out;
        end
    end

    // axi write side: address and data latched independently, answered once both are held
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [3:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_ctrl = ctrl;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // one write at a time: the pair is consumed only while no response is pending
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = CCG_RESP_OKAY;
            case (aw_addr)
                CCG_OFS_CTRL: begin
                    if (w_strb[0]) begin
                        next_ctrl = w_data[1:0];
                    end
                end
                CCG_OFS_STATUS, CCG_OFS_CYCLES: begin
                    next_bresp = CCG_RESP_OKAY;
                end
                default: begin
                    next_bresp = CCG_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CCG_RESP_OKAY;
            ctrl <= CCG_CTRL_RESET;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            ctrl <= next_ctrl;
        end
    end

    // axi read side: one outstanding read, data registered at the accept edge
    logic [31:0] status_word;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    assign s_axi_arready = ~s_axi_rvalid;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[CCG_ST_CPU_CLK] = cpu_clk;
        status_word[CCG_ST_PERIPH_CLK] = periph_clk;
        status_word[CCG_ST_CPU_RESET] = cpu_reset;
        status_word[CCG_ST_READY] = ready;
        status_word[CCG_ST_SOURCE_SEL] = pins.source_select;
        status_word[CCG_ST_SYNC_MODE] = pins.sync_mode_select;
        status_word[CCG_ST_CLEAR] = clear_active;
        status_word[CCG_ST_PHASE_LO +: 2] = phase;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_axi_rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = CCG_RESP_OKAY;
            case (s_axi_araddr)
                CCG_OFS_CTRL: begin
                    next_rdata = {30'h0000_0000, ctrl};
                end
                CCG_OFS_STATUS: begin
                    next_rdata = status_word;
                end
                CCG_OFS_CYCLES: begin
                    next_rdata = cycles;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = CCG_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CCG_RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/ccg_sync.sv ----
// two flip-flop synchroniser for a vector of independent level inputs
// assumes each bit is a slow level; multi-bit coherence is not kept
`timescale 1ns/10ps
`default_nettype none

module ccg_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule

`default_nettype wire

// ---- sim/ccg_checker.sv ----
// port assertions for the processor clock, reset and ready generator
// bound into ccg_clock_gen; pin histories absorb the synchroniser latency
`timescale 1ns/10ps
`default_nettype none
module ccg_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins
    input wire logic oscillator_in,
    input wire logic external_frequency_in,
    input wire logic source_select,
    input wire logic counter_sync_clear,
    input wire logic reset_request_n,
    input wire logic bus_ready_in_1,
    input wire logic bus_ready_in_2,
    input wire logic ready_qualifier_n_1,
    input wire logic ready_qualifier_n_2,
    // outputs
    input wire logic oscillator_out,
    input wire logic cpu_clk,
    input wire logic periph_clk,
    input wire logic cpu_reset,
    input wire logic ready,
    // read channel
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic src_q, fall_d;
    logic [4:0] rise_h, qual_h, clr_h;
    logic [2:0] age;
    wire logic src = source_select ? external_frequency_in : oscillator_in;
    wire logic qual = (bus_ready_in_1 & ~ready_qualifier_n_1)
        | (bus_ready_in_2 & ~ready_qualifier_n_2);
    // a window of five samples, since the exact sync delay is not pinned down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {src_q, fall_d, rise_h, qual_h, clr_h, age} <= '0;
        end else begin
            src_q <= src;
            fall_d <= $fell(cpu_clk);
            rise_h <= {rise_h[3:0], src & ~src_q};
            qual_h <= {qual_h[3:0], qual};
            clr_h <= {clr_h[3:0], counter_sync_clear};
            age <= (age == 3'h7) ? age : age + 3'h1;
        end
    end
    sequence s_clear_held;
        counter_sync_clear [*5];
    endsequence
    sequence s_reset_held;
        (!reset_request_n) [*6] ##0 $fell(cpu_clk);
    endsequence
    a_periph_toggle: assert property ($rose(cpu_clk) |-> $changed(periph_clk))
        else $error("periph_clk missed a cpu_clk rise");
    a_periph_steady: assert property (!$rose(cpu_clk) && !(|clr_h) |-> $stable(periph_clk))
        else $error("periph_clk moved without a cpu_clk rise");
    a_clk_from_src: assert property ($changed(cpu_clk) && !(|clr_h) |-> |rise_h)
        else $error("cpu_clk moved without a source rise");
    a_reset_on_fall: assert property ($changed(cpu_reset) |-> $fell(cpu_clk) || fall_d)
        else $error("cpu_reset moved away from a cpu_clk fall");
    a_ready_on_fall: assert property ($changed(ready) |-> $fell(cpu_clk) || fall_d)
        else $error("ready moved away from a cpu_clk fall");
    a_ready_cause: assert property ($rose(ready) |-> |qual_h)
        else $error("ready rose with no qualified ready input");
    a_clear_holds: assert property (s_clear_held |-> !cpu_clk && !periph_clk)
        else $error("clocks ran while the counter clear was held");
    a_reset_assert: assert property (s_reset_held |-> ##[0:1] cpu_reset)
        else $error("cpu_reset not raised at a fall during a request");
    a_osc_follow: assert property (age == 3'h7 |-> oscillator_out == $past(oscillator_in, 3))
        else $error("oscillator_out does not follow oscillator_in");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high while read data pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("accepted read address got no read data");
endmodule
bind ccg_clock_gen ccg_checker u_chk (.*);
`default_nettype wire

// ---- sim/ccg_clock_gen_tb_top.sv ----
// self-checking bench for the processor clock, reset and ready generator
// far side from ccg_cpu_side; pins and register bus driven from aclk
`timescale 1ns/10ps
`default_nettype none
module ccg_clock_gen_tb_top;
    import ccg_pkg::*;
    localparam int OSC_HALF = 3;
    localparam int EFI_HALF = 4;
    logic aclk, aresetn, clear_req, oscillator_in, external_frequency_in, counter_sync_clear;
    logic source_select, reset_request_n, bus_ready_in_1, bus_ready_in_2, qp;
    logic ready_qualifier_n_1, ready_qualifier_n_2, sync_mode_select;
    logic oscillator_out, cpu_clk, periph_clk, cpu_reset, ready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [4:0] code;
    logic [4:0] cor [4] = '{5'b01111, 5'b00001, 5'b00010, 5'b10000};
    int failures = 0;
    int cmp_count = 0;
    int hi, lo;
    ccg_cpu_side #(.OSC_HALF(OSC_HALF), .EFI_HALF(EFI_HALF)) u_far (.*);
    ccg_clock_gen dut (.*);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    function automatic int half(input logic s);
        return s ? EFI_HALF : OSC_HALF;
    endfunction
    function automatic logic qual(input logic [4:0] c);
        return (c[0] & ~c[2]) | (c[1] & ~c[3]);
    endfunction
    // two-stage mode also needs the level caught at the previous rise
    function automatic logic exp_ready(input logic [4:0] c, input logic prev);
        return c[4] ? qual(c) : (prev & qual(c));
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic till(ref logic s, input logic v, input string nm);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 400) begin
                $display("[FAIL] %s expected %b seen timeout", nm, v);
                failures++;
                conclude();
            end
        end while (s !== v);
    endtask
    task automatic span(ref logic s, input logic v, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s === v && n < 400);
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (40) begin
            if (!(ad && wd)) begin
                @(posedge aclk);
                ad = ad | (s_axi_awready === 1'b1);
                wd = wd | (s_axi_wready === 1'b1);
                s_axi_awvalid <= !ad;
                s_axi_wvalid <= !wd;
            end
        end
        till(s_axi_bvalid, 1'b1, "bvalid");
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        till(s_axi_arready, 1'b1, "arready");
        s_axi_arvalid <= 1'b0;
        till(s_axi_rvalid, 1'b1, "rvalid");
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        void'($urandom(32'h82a1_2e40));
        aresetn = 1'b0;
        {clear_req, source_select, qp, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {bus_ready_in_1, bus_ready_in_2, ready_qualifier_n_1, ready_qualifier_n_2} = '0;
        reset_request_n = 1'b1;
        sync_mode_select = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        chk("cpu_reset in reset", 32'h0000_0001, 32'(cpu_reset));
        chk("ready in reset", 32'h0000_0000, 32'(ready));
        aresetn <= 1'b1;
        till(cpu_reset, 1'b0, "cpu_reset release");
        for (int s = 0; s < 2; s++) begin
            source_select <= s[0];
            repeat (40) @(posedge aclk);
            till(cpu_clk, 1'b0, "cpu_clk low");
            till(cpu_clk, 1'b1, "cpu_clk high");
            span(cpu_clk, 1'b1, hi);
            span(cpu_clk, 1'b0, lo);
            chk("cpu_clk high", 32'(2 * half(s[0])), 32'(hi));
            chk("cpu_clk period", 32'(6 * half(s[0])), 32'(hi + lo));
            till(periph_clk, 1'b0, "periph_clk low");
            till(periph_clk, 1'b1, "periph_clk high");
            span(periph_clk, 1'b1, hi);
            chk("periph_clk high", 32'(6 * half(s[0])), 32'(hi));
        end
        clear_req <= 1'b1;
        repeat (40) @(posedge aclk);
        repeat (4) begin
            repeat (7) @(posedge aclk);
            chk("cpu_clk in clear", 32'h0000_0000, 32'(cpu_clk));
            chk("periph_clk in clear", 32'h0000_0000, 32'(periph_clk));
        end
        clear_req <= 1'b0;
        span(cpu_clk, 1'b0, lo);
        chk("restart after clear", 32'h0000_0001, 32'(lo <= 40));
        reset_request_n <= 1'b0;
        till(cpu_reset, 1'b1, "cpu_reset set");
        repeat (60) @(posedge aclk);
        chk("cpu_reset held", 32'h0000_0001, 32'(cpu_reset));
        reset_request_n <= 1'b1;
        till(cpu_reset, 1'b0, "cpu_reset clear");
        axw(CCG_OFS_CTRL, 32'h0000_0002);
        chk("ctrl write resp", 32'(CCG_RESP_OKAY), 32'(rs));
        till(cpu_reset, 1'b1, "soft reset");
        axr(CCG_OFS_CTRL);
        chk("ctrl readback", 32'h0000_0002, rd);
        axw(CCG_OFS_CTRL, 32'h0000_0000);
        till(cpu_reset, 1'b0, "soft reset off");
        axr(4'hc);
        chk("unmapped resp", 32'(CCG_RESP_SLVERR), 32'(rs));
        chk("unmapped data", 32'h0000_0000, rd);
        for (int i = 0; i < 20; i++) begin
            code = (i < 4) ? cor[i] : 5'($urandom);
            till(cpu_clk, 1'b0, "ready low phase");
            till(cpu_clk, 1'b1, "ready high phase");
            // changed just after the rise, so setup to the fall is met by design
            {sync_mode_select, ready_qualifier_n_2, ready_qualifier_n_1,
                bus_ready_in_2, bus_ready_in_1} <= code;
            till(cpu_clk, 1'b0, "ready fall");
            repeat (2) @(posedge aclk);
            chk("ready", 32'(exp_ready(code, qp)), 32'(ready));
            qp = qual(code);
        end
        axw(4'hc, 32'h0000_0000);
        chk("unmapped write resp", 32'(CCG_RESP_SLVERR), 32'(rs));
        // soft clear is entered while both clocks are low, so no clock edge is forced
        till(periph_clk, 1'b1, "periph rise");
        till(periph_clk, 1'b0, "periph fall");
        till(cpu_clk, 1'b0, "cpu_clk fall");
        axw(CCG_OFS_CTRL, 32'h0000_0001);
        repeat (60) @(posedge aclk);
        chk("cpu_clk in soft clear", 32'h0000_0000, 32'(cpu_clk));
        axr(CCG_OFS_STATUS);
        chk("soft clear status", 32'h0000_0250, rd & 32'h0000_0357);
        axw(CCG_OFS_CTRL, 32'h0000_0000);
        till(cpu_clk, 1'b1, "soft clear release");
        axr(CCG_OFS_CYCLES);
        hi = int'(rd);
        repeat (3) begin
            till(cpu_clk, 1'b0, "count low");
            till(cpu_clk, 1'b1, "count high");
        end
        axr(CCG_OFS_CYCLES);
        chk("cycles per rise", 32'h0000_0003, rd - 32'(hi));
        conclude();
    end
endmodule
`default_nettype wire

// ---- sim/ccg_cpu_side.sv ----
// far-side model: oscillator, external clock source and the board clear synchroniser
// assumes aclk at least four times faster than either source clock
`timescale 1ns/10ps
`default_nettype none
module ccg_cpu_side #(
    parameter int OSC_HALF = 3,
    parameter int EFI_HALF = 4
) (
    // clock and request
    input wire logic aclk,
    input wire logic clear_req,
    // source clocks and clear
    output logic oscillator_in,
    output logic external_frequency_in,
    output logic counter_sync_clear
);
    int oc = 0;
    int ec = 0;
    logic c1 = 1'b0;
    initial begin
        oscillator_in = 1'b0;
        external_frequency_in = 1'b0;
        counter_sync_clear = 1'b0;
    end
    always @(posedge aclk) begin
        oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
        ec <= (ec == EFI_HALF - 1) ? 0 : ec + 1;
        if (oc == OSC_HALF - 1) oscillator_in <= ~oscillator_in;
        if (ec == EFI_HALF - 1) external_frequency_in <= ~external_frequency_in;
    end
    // two flops on the source clock keep the clear away from its edges
    always @(posedge external_frequency_in) begin
        c1 <= clear_req;
        counter_sync_clear <= c1;
    end
endmodule
`default_nettype wire
